// file: rtl/cfcr_consts.vh
`ifndef CFCR_CONSTS_VH
`define CFCR_CONSTS_VH
`define CFCR_TARGET_ADDR    7'h38
`define CFCR_ADDR_GLOBAL    8'h00
`define CFCR_ADDR_OUT1      8'h01
`define CFCR_ADDR_OUT2      8'h02
`define CFCR_ADDR_OUT3      8'h03
`define CFCR_RST_GLOBAL     8'h44
`define CFCR_RST_CHAN       8'h06
`define CFCR_MASK_GLOBAL    8'h7f
`define CFCR_MASK_CHAN      8'h3f
`define CFCR_G_OUT_MODE     0
`define CFCR_G_REQ_TYPE     1
`define CFCR_G_REQ_POL      2
`define CFCR_G_REQ_FORCE    3
`define CFCR_G_IN_COUPLE    4
`define CFCR_G_REG_MODE_LO  5
`define CFCR_G_REG_MODE_HI  6
`define CFCR_C_LOAD_LO      0
`define CFCR_C_LOAD_HI      1
`define CFCR_C_REQ_POL      2
`define CFCR_C_FORCE_ON     3
`define CFCR_C_FORCE_OFF    4
`define CFCR_C_PULLDOWN     5
`define CFCR_REG_OFF        2'b00
`define CFCR_REG_TRACK      2'b10
`define CFCR_REG_ON         2'b11
`endif

// file: rtl/cfcr_i2c_target.v
`timescale 1ns/10ps
module cfcr_i2c_target (
    input  wire clk_sys,
    input  wire rstn,
    input  wire scl_in,
    input  wire sda_in,
    output wire scl_rise,
    output wire scl_fall,
    output wire start_c,
    output wire stop_c,
    output wire sda_s
);
    reg [2:0] scl_h;
    reg [2:0] sda_h;

    // Bits 0 and 1 are the synchroniser; bit 2 keeps the previous settled level.
    assign scl_rise = scl_h[1] & ~scl_h[2];
    assign scl_fall = ~scl_h[1] & scl_h[2];
    assign start_c  = scl_h[1] & scl_h[2] & ~sda_h[1] & sda_h[2];
    assign stop_c   = scl_h[1] & scl_h[2] & sda_h[1] & ~sda_h[2];
    assign sda_s    = sda_h[1];

    always @(posedge clk_sys) begin
        if (!rstn) begin
            // Reset to the idle-high bus level so no false edge follows reset.
            scl_h <= 3'h7;
            sda_h <= 3'h7;
        end else begin
            scl_h <= {scl_h[1:0], scl_in};
            sda_h <= {sda_h[1:0], sda_in};
        end
    end
endmodule // cfcr_i2c_target

// file: rtl/cfcr_config_regs.v
`timescale 1ns/10ps
`include "cfcr_consts.vh"
module cfcr_config_regs (
    input  wire       clk_sys,
    input  wire       rstn,
    input  wire       scl_in,
    input  wire       sda_in,
    output reg        sda_out,
    output reg        sda_oe,
    input  wire [2:0] request_in,
    output reg  [2:0] fanout_en,
    output reg  [5:0] drive_load,
    output reg  [2:0] pulldown_en,
    output reg        pair_mode,
    output reg        req_out,
    output reg        req_out_oe,
    output reg        dc_coupled,
    output reg        regulator_en
);
    localparam PH_ADDR = 4'b0001;
    localparam PH_PTR  = 4'b0010;
    localparam PH_DATA = 4'b0100;
    localparam PH_MORE = 4'b1000;

    reg  [7:0] global_config;
    reg  [7:0] chan_cfg [0:2];
    reg  [7:0] rd_data;
    reg  [7:0] reg_ptr;
    reg        wr_stb;
    reg  [7:0] wr_data;
    reg        bus_oe;
    reg  [3:0] bit_cnt;
    reg  [7:0] shift;
    reg  [3:0] phase;
    reg        active;
    reg        reading;
    reg        in_ack;
    reg        master_nak;
    wire       scl_rise;
    wire       scl_fall;
    wire       start_c;
    wire       stop_c;
    wire       sda_s;
    integer    i;
    integer    j;

    function chan_on;
        input [7:0] cfg;
        input       req;
        begin
            chan_on = ~cfg[`CFCR_C_FORCE_OFF]
                      & (cfg[`CFCR_C_FORCE_ON]
                         | (req == cfg[`CFCR_C_REQ_POL]));
        end
    endfunction

    cfcr_i2c_target cfcr_i2c_target_inst (
        .clk_sys  (clk_sys),
        .rstn     (rstn),
        .scl_in   (scl_in),
        .sda_in   (sda_in),
        .scl_rise (scl_rise),
        .scl_fall (scl_fall),
        .start_c  (start_c),
        .stop_c   (stop_c),
        .sda_s    (sda_s)
    );

    // Bits are counted on falling serial clock edges. The fall that follows a start
    // condition carries no bit, so the count starts one below zero there.
    always @(posedge clk_sys) begin
        wr_stb <= 1'b0;
        if (!rstn) begin
            bit_cnt    <= 4'h0;
            shift      <= 8'h00;
            phase      <= PH_ADDR;
            active     <= 1'b0;
            reading    <= 1'b0;
            in_ack     <= 1'b0;
            master_nak <= 1'b0;
            bus_oe     <= 1'b0;
            reg_ptr    <= 8'h00;
            wr_data    <= 8'h00;
        end else if (start_c) begin
            active  <= 1'b1;
            bit_cnt <= 4'hf;
            phase   <= PH_ADDR;
            reading <= 1'b0;
            in_ack  <= 1'b0;
            bus_oe  <= 1'b0;
        end else if (stop_c) begin
            active <= 1'b0;
            bus_oe <= 1'b0;
        end else if (active && scl_rise) begin
            if (in_ack) begin
                // Only a data byte strobes; the pointer byte must leave registers alone.
                if (!reading && phase == PH_MORE)
                    wr_stb <= 1'b1;
                if (reading)
                    master_nak <= sda_s;
            end else if (!reading) begin
                shift <= {shift[6:0], sda_s};
            end
        end else if (active && scl_fall) begin
            if (in_ack) begin
                in_ack  <= 1'b0;
                bit_cnt <= 4'h0;
                if (reading && master_nak) begin
                    active <= 1'b0;
                    bus_oe <= 1'b0;
                end else if (reading) begin
                    bus_oe <= ~rd_data[7];
                    shift  <= {rd_data[6:0], 1'b0};
                end else begin
                    bus_oe <= 1'b0;
                end
            end else if (bit_cnt == 4'h7) begin
                in_ack  <= 1'b1;
                bit_cnt <= 4'h0;
                if (reading) begin
                    bus_oe <= 1'b0;
                end else begin
                    case (phase)
                        PH_ADDR: begin
                            if (shift[7:1] == `CFCR_TARGET_ADDR) begin
                                bus_oe     <= 1'b1;
                                reading    <= shift[0];
                                master_nak <= 1'b0;
                                phase      <= PH_PTR;
                            end else begin
                                active <= 1'b0;
                            end
                        end
                        PH_PTR: begin
                            bus_oe  <= 1'b1;
                            reg_ptr <= shift;
                            phase   <= PH_DATA;
                        end
                        default: begin
                            bus_oe  <= 1'b1;
                            wr_data <= shift;
                            phase   <= PH_MORE;
                        end
                    endcase
                end
            end else begin
                bit_cnt <= bit_cnt + 4'h1;
                if (reading) begin
                    bus_oe <= ~shift[7];
                    shift  <= {shift[6:0], 1'b0};
                end
            end
        end
    end

    always @* begin
        case (reg_ptr)
            `CFCR_ADDR_GLOBAL: rd_data = global_config;
            `CFCR_ADDR_OUT1:   rd_data = chan_cfg[0];
            `CFCR_ADDR_OUT2:   rd_data = chan_cfg[1];
            `CFCR_ADDR_OUT3:   rd_data = chan_cfg[2];
            default:           rd_data = 8'h00;
        endcase
    end

    reg        any_req;
    reg        req_act;
    always @* begin
        any_req = 1'b0;
        for (j = 0; j < 3; j = j + 1)
            any_req = any_req | chan_on(chan_cfg[j], request_in[j]);
        req_act = global_config[`CFCR_G_REQ_FORCE] | any_req;
    end

    always @(posedge clk_sys) begin
        if (!rstn) begin
            global_config <= `CFCR_RST_GLOBAL;
            chan_cfg[0] <= `CFCR_RST_CHAN;
            chan_cfg[1] <= `CFCR_RST_CHAN;
            chan_cfg[2] <= `CFCR_RST_CHAN;
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
            fanout_en <= 3'h0;
            drive_load <= 6'h00;
            pulldown_en <= 3'h0;
            pair_mode <= 1'b0;
            req_out <= 1'b0;
            req_out_oe <= 1'b0;
            dc_coupled <= 1'b0;
            regulator_en <= 1'b0;
        end else begin
            if (wr_stb) begin
                case (reg_ptr)
                    `CFCR_ADDR_GLOBAL: global_config <= wr_data & `CFCR_MASK_GLOBAL;
                    `CFCR_ADDR_OUT1:   chan_cfg[0] <= wr_data & `CFCR_MASK_CHAN;
                    `CFCR_ADDR_OUT2:   chan_cfg[1] <= wr_data & `CFCR_MASK_CHAN;
                    `CFCR_ADDR_OUT3:   chan_cfg[2] <= wr_data & `CFCR_MASK_CHAN;
                    default:           ;
                endcase
            end
            sda_out <= 1'b0;
            sda_oe <= bus_oe;
            for (i = 0; i < 3; i = i + 1) begin
                fanout_en[i] <= chan_on(chan_cfg[i], request_in[i]);
                drive_load[2*i +: 2] <= chan_cfg[i][`CFCR_C_LOAD_HI:`CFCR_C_LOAD_LO];
                pulldown_en[i] <= chan_cfg[i][`CFCR_C_PULLDOWN];
            end
            pair_mode <= global_config[`CFCR_G_OUT_MODE];
            dc_coupled <= global_config[`CFCR_G_IN_COUPLE];
            // Level on the pin is the polarity applied to the asserted state.
            req_out <= req_act ~^ global_config[`CFCR_G_REQ_POL];
            // Open-drain/source drives only the asserted level and floats otherwise.
            req_out_oe <= ~global_config[`CFCR_G_REQ_TYPE] | req_act;
            case (global_config[`CFCR_G_REG_MODE_HI:`CFCR_G_REG_MODE_LO])
                `CFCR_REG_ON:    regulator_en <= 1'b1;
                `CFCR_REG_TRACK: regulator_en <= any_req;
                default:         regulator_en <= 1'b0;
            endcase
        end
    end
endmodule // cfcr_config_regs

// file: bench/cfcr_config_regs_asserts.sv
`timescale 1ns/10ps
module cfcr_config_regs_asserts (
    input wire       clk_sys,
    input wire       rstn,
    input wire       scl_in,
    input wire       sda_in,
    input wire       sda_out,
    input wire       sda_oe,
    input wire [2:0] request_in,
    input wire [2:0] fanout_en,
    input wire [5:0] drive_load,
    input wire [2:0] pulldown_en,
    input wire       pair_mode,
    input wire       req_out,
    input wire       req_out_oe,
    input wire       dc_coupled,
    input wire       regulator_en
);
    logic [2:0] rst_age;
    always @(posedge clk_sys) begin
        if (!rstn)
            rst_age <= 3'h0;
        else if (rst_age != 3'h7)
            rst_age <= rst_age + 3'h1;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    sequence settled;
        $rose(rstn) ##2 1'b1;
    endsequence
    sequence ack_held;
        sda_oe && $past(scl_in) && $past(scl_in, 2);
    endsequence
    chk_sda_never_high: assert property (!sda_out)
        else $error("data line driven high");
    chk_reset_clears: assert property (disable iff (1'b0) !rstn |=> !sda_oe && !req_out && fanout_en == 3'h0)
        else $error("outputs not cleared in reset");
    chk_reset_global: assert property (settled |-> !pair_mode && !dc_coupled)
        else $error("global defaults wrong");
    chk_reset_chan: assert property (settled |-> drive_load == 6'h2a && pulldown_en == 3'h0)
        else $error("channel defaults wrong");
    chk_reset_follow: assert property (settled |-> fanout_en == request_in)
        else $error("enables do not follow requests");
    chk_reset_reqout: assert property (settled ##1 1'b1 |-> req_out == (|fanout_en) && req_out_oe)
        else $error("request output wrong after reset");
    chk_cfg_at_ack: assert property (rst_age == 3'h7 && $changed({drive_load, pulldown_en, pair_mode, dc_coupled}) |-> ack_held)
        else $error("config changed outside acknowledge");
    chk_oe_in_low: assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in))
        else $error("data line changed while clock high");
endmodule // cfcr_config_regs_asserts
bind cfcr_config_regs cfcr_config_regs_asserts cfcr_config_regs_asserts_inst (
    .clk_sys(clk_sys), .rstn(rstn), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .request_in(request_in), .fanout_en(fanout_en), .drive_load(drive_load),
    .pulldown_en(pulldown_en), .pair_mode(pair_mode), .req_out(req_out),
    .req_out_oe(req_out_oe), .dc_coupled(dc_coupled), .regulator_en(regulator_en));

// file: bench/cfcr_host_model.sv
`timescale 1ns/10ps
`include "cfcr_consts.vh"
// Open-drain host: it only pulls the data line low or lets the pull-up win.
module cfcr_host_model (
    input  wire clk_sys,
    input  wire sda_in,
    output reg  scl,
    output reg  sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic step(input logic sl, input logic c);
        sda_low = sl;
        scl = c;
        repeat (4) @(posedge clk_sys);
        #1;
    endtask
    task automatic bit_io(input logic b, output logic r);
        step(!b, 1'b0);
        step(!b, 1'b1);
        r = sda_in;
        step(!b, 1'b1);
        step(!b, 1'b0);
    endtask
    task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], q[i]);
        bit_io(1'b1, r);
        ack = !r;
    endtask
    task automatic start;
        step(1'b0, 1'b0);
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
    endtask
    task automatic stop;
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
        step(1'b0, 1'b1);
    endtask
    task automatic wr(input logic [6:0] dev, input logic [7:0] p, input logic [7:0] d,
                      output logic ok);
        logic [7:0] q;
        logic       k0, k1, k2;
        start;
        xfer({dev, 1'b0}, q, k0);
        xfer(p, q, k1);
        xfer(d, q, k2);
        stop;
        ok = k0 & k1 & k2;
    endtask
    task automatic rd(input logic [7:0] p, output logic [7:0] d);
        logic [7:0] q;
        logic       k;
        start;
        xfer({`CFCR_TARGET_ADDR, 1'b0}, q, k);
        xfer(p, q, k);
        start;
        xfer({`CFCR_TARGET_ADDR, 1'b1}, q, k);
        xfer(8'hff, d, k);
        stop;
    endtask
endmodule // cfcr_host_model

// file: bench/clock_fanout_config_regs_tb_top.sv
`timescale 1ns/10ps
`include "cfcr_consts.vh"
module clock_fanout_config_regs_tb_top;
    logic clk_sys = 1'b0, rstn = 1'b0, scl, sda_low, ok;
    logic [2:0] request_in = 3'h0;
    wire sda_oe, sda_out, pair_mode, req_out, req_out_oe, dc_coupled, regulator_en;
    wire [2:0] fanout_en, pulldown_en;
    wire [5:0] drive_load;
    wire sda_line = !(sda_low | sda_oe);
    logic [7:0] q;
    int error_cnt = 0, checks = 0;
    typedef struct packed {logic [7:0] a, d; logic [2:0] rq; logic [7:0] rb;
        logic [2:0] fo; logic [4:0] gl;} cfcr_row_t;
    cfcr_row_t rows [9] = '{'{8'h01, 8'h2b, 3'h0, 8'h2b, 3'h1, 5'h00},
        '{8'h01, 8'h3b, 3'h0, 8'h3b, 3'h0, 5'h00}, '{8'h02, 8'hc0, 3'h0, 8'h00, 3'h2, 5'h00},
        '{8'h03, 8'h06, 3'h4, 8'h06, 3'h6, 5'h00}, '{8'h00, 8'hff, 3'h4, 8'h7f, 3'h6, 5'h1f},
        '{8'h00, 8'h18, 3'h4, 8'h18, 3'h6, 5'h09}, '{8'h00, 8'h26, 3'h4, 8'h26, 3'h6, 5'h03},
        '{8'h00, 8'h42, 3'h2, 8'h42, 3'h0, 5'h02}, '{8'h00, 8'h40, 3'h4, 8'h40, 3'h6, 5'h05}};
    always #5 clk_sys = ~clk_sys;
    cfcr_config_regs cfcr_config_regs_inst (.clk_sys(clk_sys), .rstn(rstn), .scl_in(scl),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .request_in(request_in),
        .fanout_en(fanout_en), .drive_load(drive_load), .pulldown_en(pulldown_en),
        .pair_mode(pair_mode), .req_out(req_out), .req_out_oe(req_out_oe),
        .dc_coupled(dc_coupled), .regulator_en(regulator_en));
    cfcr_host_model cfcr_host_model_inst (.clk_sys(clk_sys), .sda_in(sda_line), .scl(scl),
        .sda_low(sda_low));
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic do_reset;
        @(posedge clk_sys);
        #1 rstn = 1'b0;
        repeat (3) @(posedge clk_sys);
        #1 rstn = 1'b1;
        repeat (5) @(posedge clk_sys);
        #1;
    endtask
    initial begin
        // The tests need about 13100 cycles; the 40000-cycle limit allows about three times that.
        #400000;
        error_cnt++;
        $display("BAD %0t watchdog expired", $time);
        report_and_stop;
    end
    initial begin
        do_reset;
        for (int i = 0; i < 9; i++) begin
            cfcr_host_model_inst.wr(`CFCR_TARGET_ADDR, rows[i].a, rows[i].d, ok);
            cmp({7'h0, ok}, 8'h01);
            request_in = rows[i].rq;
            cfcr_host_model_inst.rd(rows[i].a, q);
            cmp(q, rows[i].rb);
            cmp({5'h0, fanout_en}, {5'h0, rows[i].fo});
            if (rows[i].a == 8'h00)
                cmp({3'h0, pair_mode, dc_coupled, regulator_en, req_out, req_out_oe},
                    {3'h0, rows[i].gl});
            $display("row %0d done", i);
        end
        cmp({2'h0, drive_load}, 8'h23);
        cmp({5'h0, pulldown_en}, 8'h01);
        cfcr_host_model_inst.wr(7'h39, 8'h01, 8'h00, ok);
        cmp({7'h0, ok}, 8'h00);
        cfcr_host_model_inst.wr(`CFCR_TARGET_ADDR, 8'h05, 8'h55, ok);
        cfcr_host_model_inst.rd(8'h05, q);
        cmp(q, 8'h00);
        cfcr_host_model_inst.rd(8'h01, q);
        cmp(q, 8'h3b);
        $display("refusal test done");
        do_reset;
        cfcr_host_model_inst.rd(8'h00, q);
        cmp(q, `CFCR_RST_GLOBAL);
        cfcr_host_model_inst.rd(8'h03, q);
        cmp(q, `CFCR_RST_CHAN);
        cmp({2'h0, drive_load}, 8'h2a);
        $display("reset test done");
        report_and_stop;
    end
endmodule // clock_fanout_config_regs_tb_top
